// ==== tb/smsd_host_model.sv ====
`timescale 1ns/1ps
module smsd_host_model (
  input  wire logic ref_clk_i,
  input  wire logic go_i,
  output logic      restart_req_o
);
  initial restart_req_o = 1'b0;
  // Request on every other cycle while go is high; one request cycle for a one-cycle go
  always @(posedge ref_clk_i) begin
    restart_req_o <= go_i && !restart_req_o;
  end
endmodule

// ==== tb/smsd_properties.sv ====
`timescale 1ns/1ps
module smsd_checker #(
  parameter int unsigned TEST_CYCLES   = smsd_pkg::TEST_CYCLES,
  parameter int unsigned SETTLE_CYCLES = smsd_pkg::SETTLE_CYCLES
) (
  input wire logic                   ref_clk_i,
  input wire logic                   nrst_i,
  input wire smsd_pkg::smsd_mon_t    mon_i,
  input wire logic                   restart_req_i,
  input wire logic                   fault_flag_out_o,
  input wire smsd_pkg::smsd_bridge_t bridge_o,
  input wire logic                   thr_fault_flag_out_sel_o,
  input wire logic                   busy_o,
  input wire smsd_pkg::smsd_result_t result_o,
  input wire logic [2:0]             tests_done_o
);
  logic [15:0] len_q;
  logic        none;
  assign none = result_o == smsd_pkg::SMSD_RES_NONE;
  // Length of the busy run
  always_ff @(posedge ref_clk_i) begin
    len_q <= (nrst_i && busy_o) ? len_q + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_BUSY_HIZ: assert property (busy_o |->
    !fault_flag_out_o && bridge_o == 2'h3) else $error("live in test");
  AST_RES_PINS: assert property (!busy_o && !none |->
    fault_flag_out_o == (result_o == smsd_pkg::SMSD_RES_NORMAL))
    else $error("flag vs result");
  AST_THR_T2: assert property (thr_fault_flag_out_sel_o |->
    busy_o && tests_done_o == 3'h1) else $error("shift outside test 2");
  AST_WAIT: assert property ((!busy_o && none && |mon_i)[*3] |=>
    !busy_o) else $error("start while detected");
  AST_LEN: assert property (
    $fell(busy_o) && $past(nrst_i) |-> len_q == 16'(3 * TEST_CYCLES))
    else $error("length");
  AST_ALL: assert property ($fell(busy_o) && $past(nrst_i) |->
    tests_done_o == 3'h7 && !none) else $error("tests missing");
  AST_REFUSE: assert property (
    restart_req_i && !busy_o && !none
    && |$past(mon_i) && |$past(mon_i, 2) |=> !busy_o && bridge_o == 2'h3
    && tests_done_o == 3'h0 && result_o == smsd_pkg::SMSD_RES_ABNORMAL)
    else $error("not refused");
  AST_RESTART: assert property (restart_req_i && !busy_o && !none
    && !(|$past(mon_i) || |$past(mon_i, 2))
    |=> busy_o && tests_done_o == 3'h0)
    else $error("no restart");
  cover property ($fell(busy_o) && fault_flag_out_o);
  cover property ($fell(busy_o) && !fault_flag_out_o);
  cover property (!busy_o && bridge_o == 2'h3 && !none && !fault_flag_out_o);
endmodule
bind smsd_top smsd_checker #(.TEST_CYCLES(TEST_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i), .mon_i(mon_i), .restart_req_i(restart_req_i),
  .fault_flag_out_o(fault_flag_out_o), .bridge_o(bridge_o),
  .thr_fault_flag_out_sel_o(thr_fault_flag_out_sel_o), .busy_o(busy_o),
  .result_o(result_o), .tests_done_o(tests_done_o));

// ==== tb/supply_monitor_self_diagnosis_bench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module supply_monitor_self_diagnosis_bench;
  logic                   clk, nrst, stuck, go, req, flag, thr, busy;
  logic [1:0]             btest;
  logic [2:0]             done;
  smsd_pkg::smsd_mon_t    mon;
  smsd_pkg::smsd_bridge_t brg;
  smsd_pkg::smsd_result_t res;
  int                     failures = 0, check_count = 0;
  smsd_top #(.TEST_CYCLES(20), .SETTLE_CYCLES(5)) dut (.ref_clk_i(clk),
    .nrst_i(nrst), .mon_i(mon), .restart_req_i(req), .fault_flag_out_o(flag),
    .bridge_o(brg), .thr_fault_flag_out_sel_o(thr), .busy_o(busy), .result_o(res),
    .tests_done_o(done));
  smsd_host_model host (.ref_clk_i(clk), .go_i(go), .restart_req_o(req));
  // Monitors follow the threshold; btest upsets one monitor in that test
  always @(posedge clk) begin
    mon <= smsd_pkg::smsd_mon_t'(stuck ? 3'h7 : {3{thr}} ^ {2'h0, busy
      && btest == (done == 3'h0 ? 2'h1 : done == 3'h1 ? 2'h2 : 2'h3)});
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wt(input logic lvl, input int n, output int i);
    for (i = 0; i < n && busy !== lvl; i++) @(negedge clk);
    if (i == n) begin
      failures++;
      summarize();
    end
  endtask
  task automatic kick();
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
  endtask
  task automatic fault_flag_out(input smsd_pkg::smsd_result_t r);
    int i;
    wt(1'b1, 8, i);
    `CHK("test flag", 1'b0, flag)
    `CHK("test out", 2'h3, brg)
    wt(1'b0, 200, i);
    `CHK("length", 60, i)
    `CHK("done", 3'h7, done)
    `CHK("result", r, res)
    `CHK("flag", r == smsd_pkg::SMSD_RES_NORMAL, flag)
    `CHK("out", 2'h0, brg)
  endtask
  task automatic t_power();
    repeat (8) @(negedge clk);
    `CHK("wait busy", 1'b0, busy)
    stuck = 1'b0;
    fault_flag_out(smsd_pkg::SMSD_RES_NORMAL);
  endtask
  task automatic t_bad();
    for (int k = 1; k <= 3; k++) begin
      btest = 2'(k);
      kick();
      fault_flag_out(smsd_pkg::SMSD_RES_ABNORMAL);
    end
    btest = 2'h0;
    // Let the last upset drain through the synchroniser
    repeat (4) @(negedge clk);
    kick();
    fault_flag_out(smsd_pkg::SMSD_RES_NORMAL);
  endtask
  task automatic t_refuse();
    stuck = 1'b1;
    repeat (4) @(negedge clk);
    kick();
    repeat (3) @(negedge clk);
    `CHK("refused", smsd_pkg::SMSD_RES_ABNORMAL, res)
    `CHK("refused out", 2'h3, brg)
    `CHK("refused flag", 1'b0, flag)
    `CHK("skipped", 3'h0, done)
    stuck = 1'b0;
    repeat (4) @(negedge clk);
    kick();
    fault_flag_out(smsd_pkg::SMSD_RES_NORMAL);
  endtask
  task automatic t_reset();
    int i;
    kick();
    wt(1'b1, 8, i);
    repeat (10) @(negedge clk);
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk) nrst <= 1'b1;
    @(negedge clk);
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset out", 2'h3, brg)
    `CHK("reset res", smsd_pkg::SMSD_RES_NONE, res)
    fault_flag_out(smsd_pkg::SMSD_RES_NORMAL);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    nrst  = 1'b0;
    go    = 1'b0;
    stuck = 1'b1;
    btest = 2'h0;
    mon   = smsd_pkg::smsd_mon_t'(3'h7);
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_power();
    t_bad();
    t_refuse();
    t_reset();
    summarize();
  end
endmodule

// ==== verilog/smsd_pkg.sv ====
package smsd_pkg;

  // Total sequence time, three tests share it evenly
  localparam int unsigned SEQ_TIME_NS   = 48000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned NUM_TESTS     = 3;
  localparam int unsigned TEST_CYCLES   =
    SEQ_TIME_NS / CLK_PERIOD_NS / NUM_TESTS;
  // Settle time after each threshold change, before sampling
  localparam int unsigned SETTLE_CYCLES = 100;
  localparam int unsigned CNT_W         = 16;
  localparam logic [2:0]  MON_CLEAR     = 3'h0;
  localparam logic [2:0]  MON_ALL_DET   = 3'h7;

  typedef enum logic [1:0] {
    SMSD_RES_NONE,
    SMSD_RES_NORMAL,
    SMSD_RES_ABNORMAL
  } smsd_result_t;

  // Monitor flags: bit2 battery under, bit1 logic under, bit0 logic over
  typedef struct packed {
    logic bat_uv;
    logic log_uv;
    logic log_ov;
  } smsd_mon_t;

  typedef struct packed {
    logic bridge_output_a_oe_n;
    logic bridge_output_b_oe_n;
  } smsd_bridge_t;

endpackage

// ==== verilog/smsd_sync.sv ====
`timescale 1ns/1ps
module smsd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_q;
  logic [W-1:0] s2_d;

  always_comb begin
    s1_d = d_i;
    s2_d = s1_q;
  end

  // Reset to detected so nothing starts before real levels arrive
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s1_q <= '1;
      s2_q <= '1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q_o = s2_q;
endmodule

// ==== verilog/smsd_top.sv ====
`timescale 1ns/1ps
module smsd_top #(
  parameter int unsigned TEST_CYCLES   = smsd_pkg::TEST_CYCLES,
  parameter int unsigned SETTLE_CYCLES = smsd_pkg::SETTLE_CYCLES
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  nrst_i,
  input  wire smsd_pkg::smsd_mon_t   mon_i,
  input  wire logic                  restart_req_i,
  output logic                       fault_flag_out_o,
  output smsd_pkg::smsd_bridge_t     bridge_o,
  output logic                       thr_fault_flag_out_sel_o,
  output logic                       busy_o,
  output smsd_pkg::smsd_result_t     result_o,
  output logic [2:0]                 tests_done_o
);

  typedef enum logic [2:0] {
    SMSD_WAIT_CLEAR,
    SMSD_TEST1,
    SMSD_TEST2,
    SMSD_TEST3,
    SMSD_DONE_OK,
    SMSD_DONE_BAD,
    SMSD_HALT_HIZ
  } smsd_state_t;

  smsd_state_t               state_q;
  smsd_state_t               state_d;
  logic [smsd_pkg::CNT_W-1:0] cnt_q;
  logic [smsd_pkg::CNT_W-1:0] cnt_d;
  logic                      fail_q;
  logic                      fail_d;
  logic [2:0]                done_q;
  logic [2:0]                done_d;
  smsd_pkg::smsd_result_t    res_q;
  smsd_pkg::smsd_result_t    res_d;
  logic                      flag_q;
  logic                      flag_d;
  logic                      oe_n_q;
  logic                      oe_n_d;
  logic                      thr_q;
  logic                      thr_d;
  logic [2:0]                mon_s;
  logic                      any_det;
  logic                      all_det;
  logic                      end_test;
  logic                      sample;

  // Monitors are analog and asynchronous to this clock
  smsd_sync #(
    .W(3)
  ) u_mon_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i   (nrst_i),
    .d_i      (mon_i),
    .q_o      (mon_s)
  );

  assign any_det  = (mon_s != smsd_pkg::MON_CLEAR);
  assign all_det  = (mon_s == smsd_pkg::MON_ALL_DET);
  assign end_test = (cnt_q == smsd_pkg::CNT_W'(TEST_CYCLES - 1));
  assign sample   = (cnt_q == smsd_pkg::CNT_W'(SETTLE_CYCLES));

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    fail_d  = fail_q;
    done_d  = done_q;
    res_d   = res_q;
    flag_d  = flag_q;
    oe_n_d  = oe_n_q;
    thr_d   = thr_q;
    if (state_q inside {SMSD_TEST1, SMSD_TEST2, SMSD_TEST3}) begin
      cnt_d = end_test ? '0 : cnt_q + 1'b1;
    end
    unique case (state_q)
      SMSD_WAIT_CLEAR: begin
        flag_d = 1'b0;
        oe_n_d = 1'b1;
        if (!any_det) begin
          state_d = SMSD_TEST1;
          cnt_d   = '0;
          fail_d  = 1'b0;
          done_d  = '0;
          res_d   = smsd_pkg::SMSD_RES_NONE;
        end
      end
      SMSD_TEST1: begin
        if (sample && any_det) fail_d = 1'b1;
        if (end_test) begin
          done_d[0] = 1'b1;
          thr_d     = 1'b1;
          state_d   = SMSD_TEST2;
        end
      end
      SMSD_TEST2: begin
        if (sample && !all_det) fail_d = 1'b1;
        if (end_test) begin
          done_d[1] = 1'b1;
          thr_d     = 1'b0;
          state_d   = SMSD_TEST3;
        end
      end
      SMSD_TEST3: begin
        if (end_test) begin
          done_d[2] = 1'b1;
          oe_n_d    = 1'b0;
          if (fail_q || (sample && any_det)) begin
            res_d   = smsd_pkg::SMSD_RES_ABNORMAL;
            flag_d  = 1'b0;
            state_d = SMSD_DONE_BAD;
          end else begin
            res_d   = smsd_pkg::SMSD_RES_NORMAL;
            flag_d  = 1'b1;
            state_d = SMSD_DONE_OK;
          end
        end else if (sample && any_det) begin
          fail_d = 1'b1;
        end
      end
      SMSD_DONE_OK, SMSD_DONE_BAD: begin
        if (restart_req_i) begin
          flag_d = 1'b0;
          oe_n_d = 1'b1;
          if (any_det) begin
            res_d   = smsd_pkg::SMSD_RES_ABNORMAL;
            done_d  = '0;
            state_d = SMSD_HALT_HIZ;
          end else begin
            state_d = SMSD_TEST1;
            cnt_d   = '0;
            fail_d  = 1'b0;
            done_d  = '0;
            res_d   = smsd_pkg::SMSD_RES_NONE;
          end
        end
      end
      SMSD_HALT_HIZ: begin
        flag_d = 1'b0;
        oe_n_d = 1'b1;
        if (restart_req_i && !any_det) begin
          state_d = SMSD_TEST1;
          cnt_d   = '0;
          fail_d  = 1'b0;
          done_d  = '0;
          res_d   = smsd_pkg::SMSD_RES_NONE;
        end
      end
      default: begin
        state_d = SMSD_WAIT_CLEAR;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_q <= SMSD_WAIT_CLEAR;
      cnt_q   <= '0;
      fail_q  <= 1'b0;
      done_q  <= '0;
      res_q   <= smsd_pkg::SMSD_RES_NONE;
      flag_q  <= 1'b0;
      oe_n_q  <= 1'b1;
      thr_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      fail_q  <= fail_d;
      done_q  <= done_d;
      res_q   <= res_d;
      flag_q  <= flag_d;
      oe_n_q  <= oe_n_d;
      thr_q   <= thr_d;
    end
  end

  assign fault_flag_out_o              = flag_q;
  assign bridge_o.bridge_output_a_oe_n = oe_n_q;
  assign bridge_o.bridge_output_b_oe_n = oe_n_q;
  assign thr_fault_flag_out_sel_o                = thr_q;
  assign busy_o       = state_q inside {SMSD_TEST1, SMSD_TEST2, SMSD_TEST3};
  assign result_o                      = res_q;
  assign tests_done_o                  = done_q;

endmodule
